// *** inc/smw_pkg.sv ***
/*
  Constants and carrier types for the shared memory window register set.
  Assumes an 8-bit ISA-style I/O register port and a 20-bit memory address.
*/
package smw_pkg;
  // ----------------------------------------------------------------
  // Register offsets from the switch-selected I/O base
  // ----------------------------------------------------------------
  localparam logic [2:0] OFS_CTRL   = 3'h0;  // Control slot, owned elsewhere
  localparam logic [2:0] OFS_MATCH  = 3'h1;  // Memory base match
  localparam logic [2:0] OFS_BANK   = 3'h2;  // Memory bank select
  localparam logic [2:0] OFS_SIZE   = 3'h3;  // Window size select
  localparam logic [2:0] OFS_IRQ    = 3'h4;  // Host interrupt line
  localparam logic [2:0] OFS_LED    = 3'h5;  // Indicator state
  localparam logic [2:0] OFS_RSVD   = 3'h6;  // Reserved, reads zero
  localparam logic [2:0] OFS_FAMILY = 3'h7;  // Product family code
  // ----------------------------------------------------------------
  // Reset values and writable-bit masks
  // ----------------------------------------------------------------
  localparam logic [7:0] MATCH_RST  = 8'h80;  // Top bit set
  localparam logic [7:0] SIZE_RST   = 8'h03;  // 16K window
  localparam logic [7:0] BANK_RST   = 8'h00;  // Bank zero
  localparam logic [7:0] IRQ_RST    = 8'h00;  // No line
  localparam logic [7:0] MATCH_WMSK = 8'h7e;  // Bits 6..1 writable
  localparam logic [7:0] BANK_WMSK  = 8'h3e;  // Bits 5..1 writable
  localparam logic [7:0] IRQ_WMSK   = 8'h0f;  // Level field only
  localparam logic [7:0] LED_MSK    = 8'h3f;  // Six indicator bits
  localparam logic [15:0] IRQ_OK    = 16'h9ea4;  // Lines 2,5,7,9,10,11,12,15
  localparam logic [7:0] ZERO8      = 8'h00;  // Idle read value
  // Family code value is arbitrary, not any product's real code
  localparam logic [7:0] FAMILY_CODE = 8'h5a;
  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        iow_n;     // I/O write strobe
    logic        ior_n;     // I/O read strobe
    logic        aen;       // DMA address enable
    logic        memr_n;    // Memory read strobe
    logic        memw_n;    // Memory write strobe
    logic [15:0] io_addr;   // I/O address
    logic [19:0] mem_addr;  // Memory address
    logic [7:0]  wdata;     // Write data
  } smw_pin_type;

  typedef struct packed {
    smw_pin_type s1, s2, s3;  // Three-stage pin sampler
    logic        wr_seen;     // Current write already taken
    logic [7:0]  match;       // Base match bits
    logic [7:0]  size;        // Window size bits
    logic [7:0]  bank;        // Bank select bits
    logic [7:0]  irql;        // Interrupt level field
    logic [7:0]  rdata;       // Read data to the bus
    logic        rd_oe;       // Data bus drive enable
    logic        mem_sel;     // Shared RAM selected
    logic [17:0] ram_addr;    // Shared RAM address
    logic [15:0] irq;         // Interrupt lines
  } smw_state_type;
endpackage

// *** logic/smw_regs.sv ***
/*
  Host-side register set placing a channel's shared RAM in host memory.
  Assumes asynchronous host strobes on pins and channel-side status inputs
  (memory enable, interrupt enable, flags, run, LEDs) on the same clock.
*/
`timescale 1ns/10ps
// Function
// [R1] Decode memory on base match bits 19..12
// [R2] Host keeps base within supported range
// [R3] Match bits inside window are ignored
// [R4] Size codes are ones from bit 0
// [R5] Size masks both match and bank bits
// [R6] Size resets to 16K; bits 7,6,0 fixed
// [R7] Invalid size writes are ignored
// [R8] Bank bits drive RAM address 17..13
// [R9] Bank bits inside window are don't care
// [R10] Host interface area sits in bank zero
// [R11] Host writes address bits into bank
// [R12] Host enables one channel per base
// [R13] Level field routes the chosen IRQ line
// [R14] Unsupported level drives no line
// [R15] Host avoids sharing one level
// [R16] Power LED read-only two-bit field
// [R17] Health and comm LEDs read-only codes
// [R18] Host never touches reserved location
// [R19] Family code zero unless channel running
// [R20] Respond to memory only when enabled
// [R21] Selected line high on flag and enable
// [R22] Registers at switch-selected I/O base
// [R23] Read-only and reserved bits ignore writes
// [R24] RAM address from bank and window offset
module smw_regs (
  input  wire logic        i_clk,       // 40 MHz clock
  input  wire logic        i_nrst,      // Async reset, active low
  input  wire logic [15:3] i_io_base,   // Base switch setting
  input  wire logic        i_iow_n,     // I/O write strobe pin
  input  wire logic        i_ior_n,     // I/O read strobe pin
  input  wire logic        i_aen,       // Address enable pin
  input  wire logic [15:0] i_io_addr,   // I/O address pins
  input  wire logic [7:0]  i_sd,        // Data bus in
  output logic      [7:0]  o_sd,        // Data bus out
  output logic             o_sd_oe,     // Data bus drive enable
  input  wire logic        i_memr_n,    // Memory read strobe pin
  input  wire logic        i_memw_n,    // Memory write strobe pin
  input  wire logic [19:0] i_mem_addr,  // Memory address pins
  output logic             o_mem_sel,   // Shared RAM selected
  output logic      [17:0] o_ram_addr,  // Shared RAM address
  input  wire logic        i_mem_en,    // Shared memory enable bit
  input  wire logic        i_int_en,    // Interrupt enable bit
  input  wire logic        i_flag0,     // Host interrupt flag zero
  input  wire logic        i_flag1,     // Host interrupt flag one
  input  wire logic        i_chan_run,  // Channel running
  input  wire logic [5:0]  i_led,       // LED state, red over green
  output logic      [15:0] o_irq        // Interrupt lines IRQ0..15
);
  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // A size code is a run of ones from bit 0, one to six bits long
  function automatic logic size_ok(input logic [7:0] v);
    return (v != smw_pkg::ZERO8) && (((v + 8'h01) & v) == smw_pkg::ZERO8)
           && ((v & ~smw_pkg::LED_MSK) == smw_pkg::ZERO8);  // [R4]
  endfunction

  // One-hot line for a supported level, none otherwise
  function automatic logic [15:0] irq_line(input logic [3:0] lv);
    logic [15:0] oh;
    oh = 16'h0001 << lv;
    return (oh & smw_pkg::IRQ_OK) != 16'h0000 ? oh : 16'h0000;  // [R13] [R14]
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  smw_pkg::smw_state_type q, d;       // Registered state, next value
  smw_pkg::smw_pin_type   pins;       // Raw pin bundle
  logic                   wr_agree;   // Write strobe stable low
  logic                   rd_agree;   // Read strobe stable low
  logic                   io_hit;     // Our I/O range addressed
  logic                   wr_take;    // Write accepted this cycle
  logic [2:0]             ofs;        // Register offset
  logic [7:0]             win;        // Window mask, ones inside
  logic                   mem_act;    // Memory strobe stable low
  logic                   hit_mem;    // Address in our window

  assign pins = '{iow_n: i_iow_n, ior_n: i_ior_n, aen: i_aen,
                  memr_n: i_memr_n, memw_n: i_memw_n, io_addr: i_io_addr,
                  mem_addr: i_mem_addr, wdata: i_sd};

  // ----------------------------------------------------------------
  // Decode, from the second and third sampler stages only
  // ----------------------------------------------------------------
  always_comb begin
    // The strobes come from the host bus, not from our clock; stage one may
    // be metastable, so nothing here reads it
    // A strobe counts only once stages two and three agree
    wr_agree = !q.s2.iow_n && !q.s3.iow_n;
    rd_agree = !q.s2.ior_n && !q.s3.ior_n;
    io_hit   = !q.s3.aen && (q.s3.io_addr[15:3] == i_io_base);  // [R22]
    ofs      = q.s3.io_addr[2:0];
    wr_take  = wr_agree && io_hit && !q.wr_seen;
    // Size bits are exactly the bits that lie inside the window
    win      = q.size;  // [R5]
    mem_act  = (!q.s2.memr_n && !q.s3.memr_n) || (!q.s2.memw_n && !q.s3.memw_n);
    hit_mem  = ((q.s3.mem_addr[19:12] ^ q.match) & ~win) == smw_pkg::ZERO8;  // [R1] [R3]
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d    = q;
    d.s1 = pins;
    d.s2 = q.s1;
    d.s3 = q.s2;
    // One write per strobe; re-armed once the strobe is seen high
    if (wr_take) begin
      d.wr_seen = 1'b1;
    end else if (q.s2.iow_n && q.s3.iow_n) begin
      d.wr_seen = 1'b0;
    end
    // Register writes; fixed bits keep their values
    if (wr_take) begin
      if (ofs == smw_pkg::OFS_MATCH) begin
        d.match = (q.s3.wdata & smw_pkg::MATCH_WMSK)
                | (smw_pkg::MATCH_RST & ~smw_pkg::MATCH_WMSK);  // [R1] [R23]
      end else if (ofs == smw_pkg::OFS_BANK) begin
        d.bank = q.s3.wdata & smw_pkg::BANK_WMSK;  // [R8] [R23]
      end else if (ofs == smw_pkg::OFS_SIZE) begin
        // Bad codes would open holes in the mask, so they are dropped
        if (size_ok(q.s3.wdata)) begin
          d.size = q.s3.wdata;  // [R7]
        end
      end else if (ofs == smw_pkg::OFS_IRQ) begin
        d.irql = q.s3.wdata & smw_pkg::IRQ_WMSK;  // [R14] [R23]
      end
    end
    // Read data, held while the strobe stays low
    // The control slot is answered by another block, so it is never driven
    d.rd_oe = rd_agree && io_hit && (ofs != smw_pkg::OFS_CTRL);
    if (ofs == smw_pkg::OFS_MATCH) begin
      d.rdata = q.match;
    end else if (ofs == smw_pkg::OFS_BANK) begin
      d.rdata = q.bank;
    end else if (ofs == smw_pkg::OFS_SIZE) begin
      d.rdata = q.size;
    end else if (ofs == smw_pkg::OFS_IRQ) begin
      d.rdata = q.irql;
    end else if (ofs == smw_pkg::OFS_LED) begin
      d.rdata = {2'h0, i_led} & smw_pkg::LED_MSK;  // [R16] [R17]
    end else if (ofs == smw_pkg::OFS_FAMILY) begin
      d.rdata = i_chan_run ? smw_pkg::FAMILY_CODE : smw_pkg::ZERO8;  // [R19]
    end else begin
      d.rdata = smw_pkg::ZERO8;  // Reserved location and control slot
    end
    // Shared memory decode and address
    d.mem_sel  = i_mem_en && mem_act && hit_mem;  // [R20]
    // Bank above the window, host offset inside it; bank 0 at reset
    d.ram_addr = {(q.bank[5:1] & ~win[5:1]) | (q.s3.mem_addr[17:13] & win[5:1]),
                  (q.s3.mem_addr[12] & win[0]), q.s3.mem_addr[11:0]};  // [R8] [R9] [R10] [R24]
    // Interrupt routing
    d.irq = ((i_flag0 || i_flag1) && i_int_en) ? irq_line(q.irql[3:0])
                                               : 16'h0000;  // [R21]
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      q          <= '0;
      q.s1.iow_n <= 1'b1;
      q.s2.iow_n <= 1'b1;
      q.s3.iow_n <= 1'b1;
      q.s1.ior_n <= 1'b1;
      q.s2.ior_n <= 1'b1;
      q.s3.ior_n <= 1'b1;
      // Memory strobes idle high as well, or decode would see a false cycle
      q.s1.memr_n <= 1'b1;
      q.s2.memr_n <= 1'b1;
      q.s3.memr_n <= 1'b1;
      q.s1.memw_n <= 1'b1;
      q.s2.memw_n <= 1'b1;
      q.s3.memw_n <= 1'b1;
      q.match    <= smw_pkg::MATCH_RST;  // [R1]
      q.size     <= smw_pkg::SIZE_RST;   // [R6]
      q.bank     <= smw_pkg::BANK_RST;   // [R10]
      q.irql     <= smw_pkg::IRQ_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_sd       = q.rdata;
  assign o_sd_oe    = q.rd_oe;
  assign o_mem_sel  = q.mem_sel;
  assign o_ram_addr = q.ram_addr;
  assign o_irq      = q.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  sequence size_bad_wr_s;
    wr_take && ofs == smw_pkg::OFS_SIZE && !size_ok(q.s3.wdata);
  endsequence

  sequence size_wr_s;
    wr_take && ofs == smw_pkg::OFS_SIZE && size_ok(q.s3.wdata);
  endsequence

  size_keep_a: assert property (size_bad_wr_s |=> $stable(q.size))  // [R7]
    else $error("invalid size write changed the window");
  size_take_a: assert property (size_wr_s |=> q.size == $past(q.s3.wdata))  // [R4]
    else $error("valid size write not taken");
  size_fixed_a: assert property (q.size[7:6] == 2'b00 && q.size[0])  // [R6]
    else $error("size fixed bits changed");
  match_fixed_a: assert property (q.match[7] && !q.match[0])  // [R1]
    else $error("match fixed bits changed");
  bank_fixed_a: assert property (q.bank[7:6] == 2'b00 && !q.bank[0])  // [R8]
    else $error("bank fixed bits changed");
  irq_none_a: assert property (irq_line(q.irql[3:0]) == 16'h0000 |=> o_irq == 16'h0000)  // [R14]
    else $error("line driven for unsupported level");
  irq_route_a: assert property ((i_flag0 || i_flag1) && i_int_en  // [R21]
      |=> o_irq == irq_line($past(q.irql[3:0])))
    else $error("interrupt line not routed");
  mem_off_a: assert property (!i_mem_en |=> !o_mem_sel)  // [R20]
    else $error("memory selected while disabled");
  family_a: assert property (rd_agree && io_hit && ofs == smw_pkg::OFS_FAMILY  // [R19]
      && !i_chan_run |=> o_sd_oe && o_sd == smw_pkg::ZERO8)
    else $error("family code visible while halted");
  // Bank bits outside the window, host bits inside it
  bank_addr_a: assert property (mem_act && hit_mem  // [R24]
      |=> o_ram_addr[17:13] == (($past(q.bank[5:1]) & ~$past(win[5:1]))
                               | ($past(q.s3.mem_addr[17:13]) & $past(win[5:1]))))
    else $error("ram address not from bank and offset");

  // ----------------------------------------------------------------
  // Write steps: a taken write lands on the following edge
  // ----------------------------------------------------------------
  sequence match_wr_s;
    wr_take && ofs == smw_pkg::OFS_MATCH;
  endsequence

  sequence bank_wr_s;
    wr_take && ofs == smw_pkg::OFS_BANK;
  endsequence

  sequence irq_wr_s;
    wr_take && ofs == smw_pkg::OFS_IRQ;
  endsequence

  // Only writable bits follow the data; fixed bits are checked above and in irq_rsvd_a
  match_take_a: assert property (match_wr_s  // [R1]
      |=> q.match[6:1] == $past(q.s3.wdata[6:1]))
    else $error("base match write not taken");
  bank_take_a: assert property (bank_wr_s  // [R8]
      |=> q.bank[5:1] == $past(q.s3.wdata[5:1]))
    else $error("bank select write not taken");
  irq_take_a: assert property (irq_wr_s  // [R13]
      |=> q.irql[3:0] == $past(q.s3.wdata[3:0]))
    else $error("interrupt level write not taken");
  irq_rsvd_a: assert property (q.irql[7:4] == 4'h0)  // [R14]
    else $error("interrupt reserved bits set");
  size_code_a: assert property (size_ok(q.size))  // [R4]
    else $error("window size holds an invalid code");
  // A strobe held low for many cycles must still write only once
  wr_once_a: assert property (wr_take |=> !wr_take)  // [R22]
    else $error("second write from one strobe");

  // ----------------------------------------------------------------
  // Read steps: the answer stands one edge after the decode
  // ----------------------------------------------------------------
  sequence rd_ctrl_s;
    rd_agree && io_hit && ofs == smw_pkg::OFS_CTRL;
  endsequence

  sequence rd_led_s;
    rd_agree && io_hit && ofs == smw_pkg::OFS_LED;
  endsequence

  sequence rd_run_s;
    rd_agree && io_hit && ofs == smw_pkg::OFS_FAMILY && i_chan_run;
  endsequence

  // Two drivers on the data bus would fight, so the control slot stays quiet
  ctrl_quiet_a: assert property (rd_ctrl_s |=> !o_sd_oe)  // [R22]
    else $error("control slot driven");
  led_mirror_a: assert property (rd_led_s  // [R16] [R17]
      |=> o_sd == {2'h0, $past(i_led)})
    else $error("indicator state not mirrored");
  family_run_a: assert property (rd_run_s  // [R19]
      |=> o_sd_oe && o_sd == smw_pkg::FAMILY_CODE)
    else $error("family code missing while running");

  // ----------------------------------------------------------------
  // Memory window and interrupt lines
  // ----------------------------------------------------------------
  mem_hit_a: assert property (i_mem_en && mem_act && hit_mem |=> o_mem_sel)  // [R20]
    else $error("window access not selected");
  mem_miss_a: assert property (!hit_mem |=> !o_mem_sel)  // [R3]
    else $error("access outside the window selected");
  ram_low_a: assert property (mem_act  // [R24]
      |=> o_ram_addr[11:0] == $past(q.s3.mem_addr[11:0]))
    else $error("window offset not passed to ram");
  irq_quiet_a: assert property (!i_int_en |=> o_irq == 16'h0000)  // [R21]
    else $error("line driven while interrupts disabled");
endmodule  // smw_regs

// *** sim/smw_host_bfm.sv ***
/*
  Host bus master model: I/O register cycles and shared memory cycles.
  Assumes the register block samples the strobes through a three-flop sampler.
*/
`timescale 1ns/10ps
module smw_host_bfm #(
  parameter logic [15:3] BASE = 13'h0040  // Switch-selected I/O base
) (
  input  wire logic        i_clk,       // Bus clock
  input  wire logic [7:0]  i_sd,        // Device read data
  input  wire logic        i_sd_oe,     // Device drives data bus
  input  wire logic        i_mem_sel,   // Shared RAM selected
  input  wire logic [17:0] i_ram_addr,  // Shared RAM address
  output logic             o_iow_n,     // I/O write strobe
  output logic             o_ior_n,     // I/O read strobe
  output logic             o_memr_n,    // Memory read strobe
  output logic             o_memw_n,    // Memory write strobe
  output logic      [15:0] o_io_addr,   // I/O address
  output logic      [19:0] o_mem_addr,  // Memory address
  output logic      [7:0]  o_sd         // Write data
);
  // ----------------------------------------------------------------
  // Idle bus; the reserved location is never addressed
  // ----------------------------------------------------------------
  initial begin
    o_iow_n    = 1'b1;
    o_ior_n    = 1'b1;
    o_memr_n   = 1'b1;
    o_memw_n   = 1'b1;
    o_io_addr  = 16'h0000;
    o_mem_addr = 20'h00000;
    o_sd       = 8'h00;
  end
  // Write: strobe low 5 edges, then 4 idle edges for the sampler
  task automatic io_wr(input logic [2:0] ofs, input logic [7:0] d);
    @(posedge i_clk);
    o_io_addr <= {BASE, ofs};
    o_sd      <= d;
    o_iow_n   <= 1'b0;
    repeat (5) @(posedge i_clk);
    o_iow_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    o_sd <= ~d;  // Released bus must not keep the old value
  endtask
  // Read: answer stands from edge 4, taken at edge 5
  task automatic io_rd(input logic [2:0] ofs, output logic [7:0] d, output logic oe);
    @(posedge i_clk);
    o_io_addr <= {BASE, ofs};
    o_ior_n   <= 1'b0;
    repeat (5) @(posedge i_clk);
    d  = i_sd;
    oe = i_sd_oe;
    o_ior_n <= 1'b1;
    repeat (5) @(posedge i_clk);
  endtask
  // Memory cycle; one channel only, one level only
  task automatic mem(input logic [19:0] a, input logic wr, output logic sel,
                     output logic [17:0] ra);
    @(posedge i_clk);
    o_mem_addr <= a;
    o_memr_n   <= wr;
    o_memw_n   <= ~wr;
    repeat (5) @(posedge i_clk);
    sel = i_mem_sel;
    ra  = i_ram_addr;
    o_memr_n <= 1'b1;
    o_memw_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    o_mem_addr <= ~a;  // Released address shows no stale value
  endtask
endmodule  // smw_host_bfm

// *** sim/smw_regs_tb_top.sv ***
/*
  Self-checking bench for the shared memory window register set.
  Assumes the host model above and a 40 MHz clock.
*/
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin err_count++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module smw_regs_tb_top;
  localparam logic [15:3] BASE = 13'h0040;  // I/O block at 0x200
  logic i_clk, i_nrst, i_aen, i_mem_en, i_int_en, i_flag0, i_flag1, i_chan_run, oe, sel, hit;
  logic iow_n, ior_n, memr_n, memw_n, sd_oe, mem_sel;
  logic [5:0]  i_led;                    // LED inputs
  logic [7:0]  host_sd, dev_sd, rd;      // Data buses
  logic [15:0] io_addr, irq;             // I/O address, lines
  logic [19:0] mem_addr;                 // Memory address
  logic [17:0] ram_addr, ra;             // RAM address
  logic [7:0]  sz [3] = '{8'h01, 8'h03, 8'h3f};
  logic [19:0] ma [5] = '{20'hd3abc, 20'hd2000, 20'hd4000, 20'hf1234, 20'hb1234};
  int          err_count, num_checks;
  always #12.5 i_clk = ~i_clk;
  smw_regs smw_regs_i (.i_clk(i_clk), .i_nrst(i_nrst), .i_io_base(BASE), .i_iow_n(iow_n),
    .i_ior_n(ior_n), .i_aen(i_aen), .i_io_addr(io_addr), .i_sd(host_sd), .o_sd(dev_sd),
    .o_sd_oe(sd_oe), .i_memr_n(memr_n), .i_memw_n(memw_n), .i_mem_addr(mem_addr),
    .o_mem_sel(mem_sel), .o_ram_addr(ram_addr), .i_mem_en(i_mem_en), .i_int_en(i_int_en),
    .i_flag0(i_flag0), .i_flag1(i_flag1), .i_chan_run(i_chan_run), .i_led(i_led), .o_irq(irq));
  smw_host_bfm #(.BASE(BASE)) smw_host_bfm_i (.i_clk(i_clk), .i_sd(dev_sd), .i_sd_oe(sd_oe),
    .i_mem_sel(mem_sel), .i_ram_addr(ram_addr), .o_iow_n(iow_n), .o_ior_n(ior_n),
    .o_memr_n(memr_n), .o_memw_n(memw_n), .o_io_addr(io_addr), .o_mem_addr(mem_addr),
    .o_sd(host_sd));
  // Bank bits above the window, host offset inside it
  function automatic logic [17:0] ram_exp(input logic [7:0] b, s, input logic [19:0] a);
    ram_exp = {(b[5:1] & ~s[5:1]) | (a[17:13] & s[5:1]), a[12] & s[0], a[11:0]};
  endfunction
  // Read one register and expect the block to drive it
  task automatic rd_chk(input logic [2:0] ofs, input logic [7:0] ex);
    smw_host_bfm_i.io_rd(ofs, rd, oe);
    `CHK("drive enable", 1'b1, oe)
    `CHK("read data", ex, rd)
  endtask
  task automatic end_sim;
    $display("Checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Hang guard: the whole run needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge i_clk);
    err_count++;
    end_sim();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {i_clk, i_nrst, i_aen, i_mem_en, i_int_en, i_flag0, i_flag1, i_chan_run} = 8'h00;
    i_led = 6'h00;
    repeat (8) @(posedge i_clk);
    i_nrst <= 1'b1;
    @(posedge i_clk);
    `CHK("lines idle", 16'h0000, irq)
    rd_chk(smw_pkg::OFS_MATCH, 8'h80);
    rd_chk(smw_pkg::OFS_SIZE, 8'h03);
    rd_chk(smw_pkg::OFS_BANK, 8'h00);
    rd_chk(smw_pkg::OFS_IRQ, 8'h00);
    rd_chk(smw_pkg::OFS_FAMILY, 8'h00);
    i_chan_run <= 1'b1;
    i_led      <= 6'h1b;
    rd_chk(smw_pkg::OFS_FAMILY, smw_pkg::FAMILY_CODE);
    rd_chk(smw_pkg::OFS_LED, 8'h1b);
    i_led <= 6'h24;
    smw_host_bfm_i.io_wr(smw_pkg::OFS_LED, 8'hff);
    rd_chk(smw_pkg::OFS_LED, 8'h24);
    smw_host_bfm_i.io_rd(3'h0, rd, oe);
    `CHK("control not driven", 1'b0, oe)
    smw_host_bfm_i.io_wr(smw_pkg::OFS_MATCH, 8'hff);
    rd_chk(smw_pkg::OFS_MATCH, 8'hfe);
    smw_host_bfm_i.io_wr(smw_pkg::OFS_MATCH, 8'h01);
    rd_chk(smw_pkg::OFS_MATCH, 8'h80);
    smw_host_bfm_i.io_wr(smw_pkg::OFS_BANK, 8'hff);
    rd_chk(smw_pkg::OFS_BANK, 8'h3e);
    smw_host_bfm_i.io_wr(smw_pkg::OFS_IRQ, 8'hff);
    rd_chk(smw_pkg::OFS_IRQ, 8'h0f);
    i_aen <= 1'b1;  // DMA cycle must not write
    smw_host_bfm_i.io_wr(smw_pkg::OFS_BANK, 8'h00);
    i_aen <= 1'b0;
    rd_chk(smw_pkg::OFS_BANK, 8'h3e);
    for (int i = 1; i <= 6; i++) begin
      smw_host_bfm_i.io_wr(smw_pkg::OFS_SIZE, 8'((9'h001 << i) - 9'h001));
      rd_chk(smw_pkg::OFS_SIZE, 8'((9'h001 << i) - 9'h001));
    end
    smw_host_bfm_i.io_wr(smw_pkg::OFS_SIZE, 8'h05);
    rd_chk(smw_pkg::OFS_SIZE, 8'h3f);
    smw_host_bfm_i.io_wr(smw_pkg::OFS_SIZE, 8'hff);
    rd_chk(smw_pkg::OFS_SIZE, 8'h3f);
    smw_host_bfm_i.io_wr(smw_pkg::OFS_MATCH, 8'hd0);
    smw_host_bfm_i.io_wr(smw_pkg::OFS_BANK, 8'h0a);
    i_mem_en <= 1'b1;
    for (int s = 0; s < 3; s++) begin
      smw_host_bfm_i.io_wr(smw_pkg::OFS_SIZE, sz[s]);
      for (int k = 0; k < 5; k++) begin
        smw_host_bfm_i.mem(ma[k], k[0], sel, ra);
        hit = (((ma[k][19:12] ^ 8'hd0) & ~sz[s]) == 8'h00);
        `CHK("window select", hit, sel)
        if (hit) `CHK("ram address", ram_exp(8'h0a, sz[s], ma[k]), ra)
      end
    end
    i_mem_en <= 1'b0;
    smw_host_bfm_i.mem(20'hd0000, 1'b0, sel, ra);
    `CHK("disabled select", 1'b0, sel)
    i_int_en <= 1'b1;
    i_flag0  <= 1'b1;
    for (int c = 0; c < 16; c++) begin
      smw_host_bfm_i.io_wr(smw_pkg::OFS_IRQ, 8'(c));
      hit = (c == 2 || c == 5 || c == 7 || c == 9 || c == 10 || c == 11 || c == 12 || c == 15);
      `CHK("irq lines", hit ? 16'(17'h00001 << c) : 16'h0000, irq)
    end
    i_flag0 <= 1'b0;
    i_flag1 <= 1'b1;
    repeat (3) @(posedge i_clk);
    `CHK("irq flag one", 16'h8000, irq)
    i_int_en <= 1'b0;
    repeat (3) @(posedge i_clk);
    `CHK("irq disabled", 16'h0000, irq)
    end_sim();
  end
endmodule  // smw_regs_tb_top
